// ==== logic/tlr_bank.sv ====
// Purpose: overflow limits, stop holdoff and interval and tally results of the converter
// Assumes: host on the serial port; counters tick on sys_clk and coarse_tick
// Notes: one stop per measurement; results carry even parity in bit 23
`timescale 1ns/1ns
`default_nettype none
`include "tlr_defs.svh"

module tlr_bank (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe_n,
	input wire logic meas_start,
	input wire logic meas_stop,
	input wire logic coarse_tick,
	input wire logic [22:0] interval_value,
	input wire logic avg_mode,
	input wire logic coarse_ovf_clear,
	input wire logic clock_ovf_clear,
	output logic coarse_overflow_flag,
	output logic clock_overflow_flag,
	output logic meas_running
);

	// ****************************************
	// serial port and write decode
	// ****************************************
	tlr_pkg::tlr_wr_t wr;
	logic [5:0] rd_addr;
	logic [23:0] rd_data;

	tlr_spi_port tlr_spi_port_i (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe_n(spi_sdo_oe_n),
		.addr_q(rd_addr),
		.rd_data(rd_data),
		.wr_q(wr)
	);

	logic [7:0] coarse_limit_high_q;
	logic [7:0] coarse_limit_low_q;
	logic [7:0] clock_limit_high_q;
	logic [7:0] clock_limit_low_q;
	logic [7:0] stop_holdoff_high_q;
	logic [7:0] stop_holdoff_low_q;
	tlr_pkg::tlr_result_t first_interval_q;
	tlr_pkg::tlr_result_t first_clock_tally_q;
	tlr_pkg::tlr_result_t second_interval_q;

	// result addresses have no write strobe: writes there are dropped
	wire wr_coarse_hi = wr.valid && wr.addr == `TLR_ADR_COARSE_HI;
	wire wr_coarse_lo = wr.valid && wr.addr == `TLR_ADR_COARSE_LO;
	wire wr_clock_hi = wr.valid && wr.addr == `TLR_ADR_CLOCK_HI;
	wire wr_clock_lo = wr.valid && wr.addr == `TLR_ADR_CLOCK_LO;
	wire wr_hold_hi = wr.valid && wr.addr == `TLR_ADR_HOLD_HI;
	wire wr_hold_lo = wr.valid && wr.addr == `TLR_ADR_HOLD_LO;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			coarse_limit_high_q <= `TLR_RST_LIMIT;
			coarse_limit_low_q <= `TLR_RST_LIMIT;
			clock_limit_high_q <= `TLR_RST_LIMIT;
			clock_limit_low_q <= `TLR_RST_LIMIT;
			stop_holdoff_high_q <= `TLR_RST_HOLD;
			stop_holdoff_low_q <= `TLR_RST_HOLD;
		end else begin
			if (wr_coarse_hi) coarse_limit_high_q <= wr.data;
			if (wr_coarse_lo) coarse_limit_low_q <= wr.data;
			if (wr_clock_hi) clock_limit_high_q <= wr.data;
			if (wr_clock_lo) clock_limit_low_q <= wr.data;
			if (wr_hold_hi) stop_holdoff_high_q <= wr.data;
			if (wr_hold_lo) stop_holdoff_low_q <= wr.data;
		end
	end

	// ****************************************
	// read multiplexer
	// ****************************************
	assign rd_data =
		(rd_addr == `TLR_ADR_COARSE_HI) ? {16'h0000, coarse_limit_high_q} :
		(rd_addr == `TLR_ADR_COARSE_LO) ? {16'h0000, coarse_limit_low_q} :
		(rd_addr == `TLR_ADR_CLOCK_HI) ? {16'h0000, clock_limit_high_q} :
		(rd_addr == `TLR_ADR_CLOCK_LO) ? {16'h0000, clock_limit_low_q} :
		(rd_addr == `TLR_ADR_HOLD_HI) ? {16'h0000, stop_holdoff_high_q} :
		(rd_addr == `TLR_ADR_HOLD_LO) ? {16'h0000, stop_holdoff_low_q} :
		(rd_addr == `TLR_ADR_INTERVAL1) ? first_interval_q :
		(rd_addr == `TLR_ADR_TALLY1) ? first_clock_tally_q :
		(rd_addr == `TLR_ADR_INTERVAL2) ? second_interval_q :
		24'h00_0000;

	// ****************************************
	// measurement counters
	// ****************************************
	logic [15:0] clock_cnt_q;
	logic [15:0] coarse_cnt_q;

	wire [15:0] coarse_limit = {coarse_limit_high_q, coarse_limit_low_q};
	wire [15:0] clock_limit = {clock_limit_high_q, clock_limit_low_q};
	wire [15:0] stop_holdoff = {stop_holdoff_high_q, stop_holdoff_low_q};
	// a coarse limit of one would trip before the first tick settles
	wire coarse_hit = meas_running && coarse_cnt_q == coarse_limit;
	wire clock_hit = meas_running && clock_cnt_q == clock_limit;
	wire stop_open = clock_cnt_q >= stop_holdoff;
	wire stop_take = meas_running && meas_stop && stop_open &&
		!coarse_hit && !clock_hit;
	wire start_take = meas_start && !meas_running;
	wire [22:0] tally_sum = first_clock_tally_q.value + {7'h00, clock_cnt_q};
	// averaging keeps adding into the upper bits; otherwise they stay zero
	wire [22:0] tally_next = avg_mode ? tally_sum : {7'h00, clock_cnt_q};

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meas_running <= 1'b0;
			clock_cnt_q <= 16'h0000;
			coarse_cnt_q <= 16'h0000;
			coarse_overflow_flag <= 1'b0;
			clock_overflow_flag <= 1'b0;
			first_interval_q <= `TLR_RST_RESULT;
			first_clock_tally_q <= `TLR_RST_RESULT;
			second_interval_q <= `TLR_RST_RESULT;
		end else begin
			// set wins over a clear arriving in the same cycle
			coarse_overflow_flag <= coarse_hit ||
				(coarse_overflow_flag && !coarse_ovf_clear);
			clock_overflow_flag <= clock_hit ||
				(clock_overflow_flag && !clock_ovf_clear);
			if (start_take) begin
				meas_running <= 1'b1;
				clock_cnt_q <= 16'h0000;
				coarse_cnt_q <= 16'h0000;
				first_interval_q <= {^interval_value, interval_value};
			end else if (coarse_hit || clock_hit) begin
				meas_running <= 1'b0;
			end else if (stop_take) begin
				meas_running <= 1'b0;
				second_interval_q <= {^interval_value, interval_value};
				first_clock_tally_q <= {^tally_next, tally_next};
			end else if (meas_running) begin
				clock_cnt_q <= clock_cnt_q + 16'h0001;
				if (coarse_tick) coarse_cnt_q <= coarse_cnt_q + 16'h0001;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_coarse_hit;
		meas_running && coarse_cnt_q == coarse_limit;
	endsequence

	sequence s_stopped_flagged(logic f);
		f && !meas_running;
	endsequence

	a_coarse_overflow_stop: assert property (
		s_coarse_hit |=> s_stopped_flagged(coarse_overflow_flag))
		else $error("coarse limit did not flag and stop");

	a_clock_overflow_stop: assert property (
		clock_hit |=> s_stopped_flagged(clock_overflow_flag))
		else $error("clock limit did not flag and stop");

	a_stop_holdoff_masks: assert property (
		meas_running && meas_stop && clock_cnt_q < stop_holdoff && !meas_start
		|=> $stable(second_interval_q) && $stable(first_clock_tally_q))
		else $error("stop taken inside holdoff");

	a_coarse_low_write: assert property (
		wr_coarse_lo |=> coarse_limit_low_q == $past(wr.data))
		else $error("coarse low byte not written");

	a_coarse_high_write: assert property (
		wr_coarse_hi |=> coarse_limit_high_q == $past(wr.data))
		else $error("coarse high byte not written");

	a_clock_high_write: assert property (
		wr_clock_hi |=> clock_limit_high_q == $past(wr.data))
		else $error("clock high byte not written");

	a_clock_low_write: assert property (
		wr_clock_lo |=> clock_limit_low_q == $past(wr.data))
		else $error("clock low byte not written");

	a_holdoff_write: assert property (
		wr_hold_hi |=> stop_holdoff_high_q == $past(wr.data))
		else $error("holdoff high byte not written");

	a_holdoff_low_write: assert property (
		wr_hold_lo |=> stop_holdoff_low_q == $past(wr.data))
		else $error("holdoff low byte not written");

	a_result_parity: assert property (
		^first_interval_q == 1'b0 && ^second_interval_q == 1'b0)
		else $error("interval parity wrong");

	a_tally_upper_zero: assert property (
		stop_take && !avg_mode |=> first_clock_tally_q.value[22:16] == 7'h00)
		else $error("tally upper bits set outside averaging");

	a_result_readonly: assert property (
		wr.valid && wr.addr >= `TLR_ADR_WIDE_BASE && !meas_running
		&& !meas_start |=> $stable(first_interval_q))
		else $error("write reached a result register");

endmodule : tlr_bank
`default_nettype wire

// ==== logic/tlr_defs.svh ====
// Purpose: constants of the limit and result register bank
// Assumes: 6-bit register addresses carried in the serial command byte
// Notes: definitions only
`ifndef TLR_DEFS_SVH
`define TLR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define TLR_ADR_COARSE_HI 6'h04
`define TLR_ADR_COARSE_LO 6'h05
`define TLR_ADR_CLOCK_HI 6'h06
`define TLR_ADR_CLOCK_LO 6'h07
`define TLR_ADR_HOLD_HI 6'h08
`define TLR_ADR_HOLD_LO 6'h09
`define TLR_ADR_INTERVAL1 6'h10
`define TLR_ADR_TALLY1 6'h11
`define TLR_ADR_INTERVAL2 6'h12
// first address of the 24-bit registers
`define TLR_ADR_WIDE_BASE 6'h10

// ****************************************
// reset values
// ****************************************
`define TLR_RST_LIMIT 8'hFF
`define TLR_RST_HOLD 8'h00
`define TLR_RST_RESULT 24'h00_0000

// ****************************************
// field positions
// ****************************************
`define TLR_PARITY_BIT 23
`define TLR_VALUE_MSB 22
`define TLR_COUNT_MSB 15
`define TLR_CMD_AUTOINC_BIT 7
`define TLR_CMD_WRITE_BIT 6

// ****************************************
// serial frame lengths in bits
// ****************************************
`define TLR_CMD_BITS 5'd8
`define TLR_NARROW_BITS 5'd8
`define TLR_WIDE_BITS 5'd24

`endif

// ==== logic/tlr_pkg.sv ====
// Purpose: types shared by the register bank and its serial port
// Assumes: nothing beyond the defs header
// Notes: no constants live here, only types
`default_nettype none
package tlr_pkg;

	// register write strobe from the serial port
	typedef struct packed {
		logic valid;
		logic [5:0] addr;
		logic [7:0] data;
	} tlr_wr_t;

	// 24-bit result word: parity over a 23-bit value
	typedef struct packed {
		logic parity;
		logic [22:0] value;
	} tlr_result_t;

	typedef enum logic [1:0] {
		TLR_SPI_CMD,
		TLR_SPI_WR,
		TLR_SPI_RD
	} tlr_spi_state_t;

endpackage : tlr_pkg
`default_nettype wire

// ==== logic/tlr_spi_port.sv ====
// Purpose: serial slave giving the host byte and word access to registers
// Assumes: clock mode 0, pins synchronous to sys_clk and far slower
// Notes: command byte is autoinc, write, then 6 address bits
`timescale 1ns/1ns
`default_nettype none
`include "tlr_defs.svh"

module tlr_spi_port (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe_n,
	output logic [5:0] addr_q,
	input wire logic [23:0] rd_data,
	output tlr_pkg::tlr_wr_t wr_q
);

	tlr_pkg::tlr_spi_state_t state_q;
	logic sclk_q;
	logic [4:0] cnt_q;
	logic [23:0] sh_q;
	logic autoinc_q;
	logic load_q;

	wire sclk_rise = spi_sclk & ~sclk_q & ~spi_cs_n;
	wire sclk_fall = ~spi_sclk & sclk_q & ~spi_cs_n;
	wire [4:0] cnt_inc = cnt_q + 5'd1;
	wire [5:0] addr_inc = addr_q + 6'h01;
	wire [7:0] cmd_byte = {sh_q[6:0], spi_sdi};
	wire wide = addr_q >= `TLR_ADR_WIDE_BASE;
	wire [4:0] rd_len = wide ? `TLR_WIDE_BITS : `TLR_NARROW_BITS;
	wire [23:0] rd_align = wide ? rd_data : {rd_data[7:0], 16'h0000};

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= tlr_pkg::TLR_SPI_CMD;
			sclk_q <= 1'b0;
			cnt_q <= 5'h00;
			sh_q <= 24'h00_0000;
			autoinc_q <= 1'b0;
			load_q <= 1'b0;
			addr_q <= 6'h00;
			wr_q <= '0;
			spi_sdo <= 1'b0;
			spi_sdo_oe_n <= 1'b1;
		end else begin
			sclk_q <= spi_sclk;
			wr_q.valid <= 1'b0;
			load_q <= 1'b0;
			if (spi_cs_n) begin
				state_q <= tlr_pkg::TLR_SPI_CMD;
				cnt_q <= 5'h00;
				spi_sdo_oe_n <= 1'b1;
			end else if (load_q) begin
				// read data fetched a cycle after the address settled
				sh_q <= rd_align;
				spi_sdo <= rd_align[23];
			end else if (sclk_fall) begin
				spi_sdo <= sh_q[23];
			end else if (sclk_rise) begin
				sh_q <= {sh_q[22:0], spi_sdi};
				cnt_q <= cnt_inc;
				case (state_q)
					tlr_pkg::TLR_SPI_CMD: begin
						if (cnt_inc == `TLR_CMD_BITS) begin
							cnt_q <= 5'h00;
							addr_q <= cmd_byte[5:0];
							autoinc_q <= cmd_byte[`TLR_CMD_AUTOINC_BIT];
							if (cmd_byte[`TLR_CMD_WRITE_BIT]) begin
								state_q <= tlr_pkg::TLR_SPI_WR;
							end else begin
								state_q <= tlr_pkg::TLR_SPI_RD;
								load_q <= 1'b1;
								spi_sdo_oe_n <= 1'b0;
							end
						end
					end
					tlr_pkg::TLR_SPI_WR: begin
						if (cnt_inc == `TLR_NARROW_BITS) begin
							cnt_q <= 5'h00;
							wr_q <= '{valid: 1'b1, addr: addr_q, data: cmd_byte};
							if (autoinc_q) begin
								addr_q <= addr_inc;
							end
						end
					end
					default: begin
						if (cnt_inc == rd_len) begin
							cnt_q <= 5'h00;
							if (autoinc_q) begin
								addr_q <= addr_inc;
							end
							load_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

endmodule : tlr_spi_port
`default_nettype wire

// ==== sim/tdc_limit_and_result_registers_bench.sv ====
// Purpose: self-checking bench for the limit and result register bank
// Assumes: host model on the serial port, inputs driven at falling edges
// Notes: tally is expected to equal the holdoff when stop is held high and averaging is off
`timescale 1ns/1ns
`default_nettype none
`include "tlr_defs.svh"

module tdc_limit_and_result_registers_bench;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
	logic meas_start = 1'h0, meas_stop = 1'h0, coarse_tick = 1'h0;
	logic avg_mode = 1'h0, coarse_ovf_clear = 1'h0, clock_ovf_clear = 1'h0;
	logic [22:0] interval_value = 23'h00_0000;
	logic coarse_overflow_flag, clock_overflow_flag, meas_running;
	int mismatches = 0;
	int total_checks = 0;

	always #5 sys_clk = ~sys_clk;

	tlr_host tlr_host_i (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	tlr_bank tlr_bank_i (.sys_clk(sys_clk), .nrst(nrst),
		.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
		.meas_start(meas_start), .meas_stop(meas_stop),
		.coarse_tick(coarse_tick), .interval_value(interval_value),
		.avg_mode(avg_mode), .coarse_ovf_clear(coarse_ovf_clear),
		.clock_ovf_clear(clock_ovf_clear),
		.coarse_overflow_flag(coarse_overflow_flag),
		.clock_overflow_flag(clock_overflow_flag),
		.meas_running(meas_running));

	// ****************************************
	// helpers
	// ****************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [23:0] par(input logic [22:0] v);
		return {^v, v};
	endfunction : par

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [23:0] unused;
		if (a == `TLR_ADR_COARSE_LO && d == 8'h01) d = 8'h02;
		tlr_host_i.xfer({2'h1, a}, 8, {16'h0000, d}, unused);
	endtask : wr

	task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
		logic [23:0] v;
		tlr_host_i.xfer({2'h0, a}, (a >= 6'h10) ? 24 : 8, 24'h00_0000, v);
		check(v, exp);
	endtask : rchk

	task automatic measure(input logic [22:0] a, input logic [22:0] b);
		@(negedge sys_clk);
		interval_value = a;
		meas_start = 1'h1;
		meas_stop = 1'h1;
		@(negedge sys_clk);
		meas_start = 1'h0;
		interval_value = b;
	endtask : measure

	task automatic wait_idle(input int lim);
		int k;
		for (k = 0; k < lim && meas_running !== 1'h0; k++)
			@(negedge sys_clk);
		check({23'h0, meas_running}, 24'h0);
		meas_stop = 1'h0;
	endtask : wait_idle

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [5:0] a;
		for (a = 6'h04; a <= 6'h09; a++)
			rchk(a, (a < 6'h08) ? 24'h00_00FF : 24'h00_0000);
		rchk(6'h10, 24'h00_0000);
		rchk(6'h11, 24'h00_0000);
		rchk(6'h12, 24'h00_0000);
		check({23'h0, spi_sdo_oe_n}, 24'h00_0001);
		$display("test reset done");
	endtask : t_reset

	task automatic t_rw;
		logic [5:0] a;
		logic [23:0] v;
		for (a = 6'h04; a <= 6'h09; a++)
			wr(a, 8'hC0 | {2'h0, a});
		for (a = 6'h04; a <= 6'h09; a++)
			rchk(a, {18'h0_0003, a});
		wr(6'h10, 8'h5A);
		rchk(6'h10, 24'h00_0000);
		rchk(6'h0A, 24'h00_0000);
		// auto-increment: one frame writes 08h then 09h, one reads both
		tlr_host_i.xfer(8'hC8, 16, 24'h00_A55A, v);
		tlr_host_i.xfer(8'h88, 16, 24'h00_0000, v);
		check(v, 24'h00_A55A);
		$display("test read write done");
	endtask : t_rw

	task automatic t_holdoff;
		logic [5:0] a;
		for (a = 6'h04; a <= 6'h07; a++)
			wr(a, 8'hFF);
		wr(6'h08, 8'h00);
		wr(6'h09, 8'h14);
		measure(23'h12_3456, 23'h7F_0001);
		repeat (10) @(negedge sys_clk);
		check({23'h0, meas_running}, 24'h00_0001);
		wait_idle(40);
		rchk(6'h11, par(23'h00_0014));
		rchk(6'h10, par(23'h12_3456));
		rchk(6'h12, par(23'h7F_0001));
		avg_mode = 1'h1;
		wr(6'h09, 8'h05);
		measure(23'h00_0003, 23'h00_0007);
		wait_idle(40);
		avg_mode = 1'h0;
		rchk(6'h11, par(23'h00_0019));
		$display("test holdoff done");
	endtask : t_holdoff

	task automatic t_ovf;
		wr(6'h08, 8'hFF);
		wr(6'h09, 8'hFF);
		wr(6'h06, 8'h00);
		wr(6'h07, 8'h30);
		measure(23'h00_0001, 23'h00_0002);
		repeat (40) @(negedge sys_clk);
		check({23'h0, meas_running}, 24'h00_0001);
		wait_idle(20);
		check({22'h0, clock_overflow_flag, coarse_overflow_flag}, 24'h2);
		wr(6'h06, 8'hFF);
		wr(6'h07, 8'hFF);
		wr(6'h04, 8'h00);
		wr(6'h05, 8'h05);
		coarse_tick = 1'h1;
		measure(23'h00_0001, 23'h00_0002);
		wait_idle(20);
		coarse_tick = 1'h0;
		check({23'h0, coarse_overflow_flag}, 24'h00_0001);
		coarse_ovf_clear = 1'h1;
		clock_ovf_clear = 1'h1;
		@(negedge sys_clk);
		coarse_ovf_clear = 1'h0;
		clock_ovf_clear = 1'h0;
		@(negedge sys_clk);
		check({22'h0, clock_overflow_flag, coarse_overflow_flag}, 24'h0);
		$display("test overflow done");
	endtask : t_ovf

	initial begin
		repeat (4) @(negedge sys_clk);
		nrst = 1'h1;
		t_reset();
		t_rw();
		t_holdoff();
		t_ovf();
		report_and_stop();
	end

	// about 45 frames of at most 265 cycles each, with ample margin
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		report_and_stop();
	end
endmodule : tdc_limit_and_result_registers_bench
`default_nettype wire

// ==== sim/tlr_host.sv ====
// Purpose: host serial master for the register port
// Assumes: clock mode 0, four sys_clk per serial half period
// Notes: the bench calls xfer by hierarchical reference
`timescale 1ns/1ns
`default_nettype none
`include "tlr_defs.svh"

module tlr_host (
	input wire logic sys_clk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	initial begin
		spi_cs_n = 1'h1;
		spi_sclk = 1'h0;
		spi_sdi = 1'h0;
	end

	task automatic half;
		repeat (4) @(negedge sys_clk);
	endtask : half

	// one frame: command byte, then n data bits, msb first both ways
	task automatic xfer(input logic [7:0] cmd, input int n,
		input logic [23:0] wd, output logic [23:0] rd);
		logic [31:0] sh;
		int k;
		int last;
		sh = {cmd, wd << (24 - n)};
		rd = 24'h00_0000;
		// reads and writes alike: eight command rises, then n data rises
		last = 8 + n;
		@(negedge sys_clk);
		spi_cs_n = 1'h0;
		for (k = 0; k < last; k++) begin
			spi_sdi = sh[31 - k];
			half();
			// device shifts out after falls and reloads after the last
			// rise of a word, so each bit is taken just before sclk rises
			if (k >= 8)
				rd = {rd[22:0], spi_sdo};
			spi_sclk = 1'h1;
			half();
			spi_sclk = 1'h0;
		end
		half();
		spi_cs_n = 1'h1;
		// released line: inverse level so a stale bit cannot match
		spi_sdi = ~spi_sdi;
		half();
	endtask : xfer
endmodule : tlr_host
`default_nettype wire
